// File: rtl/i2c_switch_enable_expanders.sv
// Two two-wire bus port expanders driving board switch enables.
// Assumes SCL/SDA pins are asynchronous and pulled up outside; SDA is open drain.
`timescale 1ns/10ps
module i2c_switch_enable_expanders
  import ise_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // Two-wire bus pins
  input  wire logic         i_scl,
  input  wire logic         i_sda,
  output logic              o_sda_out,
  output logic              o_sda_oe,
  // First expander pins
  output ise_exp0_pa_t      o_exp0_port_a,
  output logic        [7:0] o_exp0_port_a_oe,
  output ise_exp0_pb_t      o_exp0_port_b,
  output logic        [7:0] o_exp0_port_b_oe,
  // Second expander pins
  output logic        [7:0] o_exp1_port_a,
  output logic        [7:0] o_exp1_port_a_oe,
  output logic        [7:0] o_exp1_port_b,
  output logic        [7:0] o_exp1_port_b_oe
);

  logic       scl_s1_r, scl_s2_r, scl_s3_r;
  logic       sda_s1_r, sda_s2_r, sda_s3_r;
  logic       scl_rise, scl_fall, start_det, stop_det;
  ise_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic       sel_r;
  logic       rw_r;
  logic       nack_r;
  logic       sda_oe_r;
  logic       wr_r;
  logic [7:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic       addr_hit0, addr_hit1;
  logic [7:0] reg_idx;
  logic [7:0] rd0, rd1, rd_mux;
  logic [7:0] p0a, p0b;

  // Two flops before use; the third stage only feeds edge detection
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // Bus events
  assign scl_rise  = scl_s2_r & ~scl_s3_r;
  assign scl_fall  = ~scl_s2_r & scl_s3_r;
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // Address compare on the seven upper bits; the low bit is direction
  assign addr_hit0 = (shift_r[7:1] == ISE_EXP0_ADDR);
  assign addr_hit1 = (shift_r[7:1] == ISE_EXP1_ADDR);

  // Shared index: a pending write takes precedence over read lookup
  assign reg_idx = wr_r ? wr_idx_r : ptr_r;
  assign rd_mux  = sel_r ? rd1 : rd0;

  // Bus target sequencer; SDA changes only after SCL falls
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      sel_r     <= 1'b0;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
      wr_r      <= 1'b0;
      wr_idx_r  <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      if (start_det) begin
        // Start or repeated start always restarts address phase
        state_r  <= ST_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise && cnt_r != ISE_BYTE_BITS) begin
              shift_r <= {shift_r[6:0], sda_s2_r};
              cnt_r   <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == ISE_BYTE_BITS) begin
              cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (addr_hit0 || addr_hit1) begin
                  sel_r    <= addr_hit1;
                  rw_r     <= shift_r[0];
                  sda_oe_r <= 1'b1;
                  state_r  <= ST_ADDR_ACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else if (state_r == ST_REG) begin
                ptr_r    <= shift_r;
                sda_oe_r <= 1'b1;
                state_r  <= ST_REG_ACK;
              end else begin
                wr_r      <= 1'b1;
                wr_idx_r  <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r     <= ptr_r + 8'h01; // Sequential writes
                sda_oe_r  <= 1'b1;
                state_r   <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                tx_r     <= rd_mux;
                sda_oe_r <= ~rd_mux[7];
                ptr_r    <= ptr_r + 8'h01;
                state_r  <= ST_RDATA;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_REG;
              end
            end
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise && cnt_r != ISE_BYTE_BITS) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == ISE_BYTE_BITS) begin
              sda_oe_r <= 1'b0; // Let master acknowledge
              state_r  <= ST_RDATA_ACK;
            end else if (scl_fall) begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              nack_r <= sda_s2_r;
              cnt_r  <= 4'h0;
            end else if (scl_fall) begin
              if (nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                tx_r     <= rd_mux;
                sda_oe_r <= ~rd_mux[7];
                ptr_r    <= ptr_r + 8'h01;
                state_r  <= ST_RDATA;
              end
            end
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: the pin only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_oe_r;

  // First expander: gate lines for serial, fieldbus, audio, card and flash
  ise_expander_regs u_exp0 (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wr_en   (wr_r & ~sel_r),
    .i_reg_idx (reg_idx),
    .i_wr_data (wr_data_r),
    .o_rd_data (rd0),
    .o_port_a  (p0a),
    .o_port_b  (p0b),
    .o_drive_a (o_exp0_port_a_oe),
    .o_drive_b (o_exp0_port_b_oe)
  );

  // Second expander
  ise_expander_regs u_exp1 (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wr_en   (wr_r & sel_r),
    .i_reg_idx (reg_idx),
    .i_wr_data (wr_data_r),
    .o_rd_data (rd1),
    .o_port_a  (o_exp1_port_a),
    .o_port_b  (o_exp1_port_b),
    .o_drive_a (o_exp1_port_a_oe),
    .o_drive_b (o_exp1_port_b_oe)
  );

  // Named gate views of the first expander's latches
  assign o_exp0_port_a = ise_exp0_pa_t'(p0a);
  assign o_exp0_port_b = ise_exp0_pb_t'(p0b);

  // First address is acknowledged and selects the first bank
  addr_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && addr_hit0 && !start_det && !stop_det)
      |=> (state_r == ST_ADDR_ACK && o_sda_oe && !sel_r))
    else $error("first expander address not acknowledged");

  // Second address is acknowledged and selects the second bank
  addr_second_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && addr_hit1 && !start_det && !stop_det)
      |=> (state_r == ST_ADDR_ACK && o_sda_oe && sel_r))
    else $error("second expander address not acknowledged");

  // Port A write reaches the eeprom, link and second fieldbus gates
  gate_port_a_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_r && !sel_r && wr_idx_r == ISE_REG_OUT_A)
      |=> (o_exp0_port_a.media_link_gate == $past(wr_data_r[5])
           && o_exp0_port_a.second_fieldbus_gate == $past(wr_data_r[7])
           && o_exp0_port_a.eeprom_select_gate == $past(wr_data_r[0])))
    else $error("port A gate lines do not follow write");

  // Port B bits 1 and 2 reach the audio ADC gate and the jack select
  audio_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_r && !sel_r && wr_idx_r == ISE_REG_OUT_B)
      |=> (o_exp0_port_b.jack_direction_select == $past(wr_data_r[2])
           && o_exp0_port_b.audio_adc_gate == $past(wr_data_r[1])))
    else $error("audio gate lines do not follow write");

  // Port B bits 3, 5 and 7 reach card, flash and digital audio gates
  flash_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_r && !sel_r && wr_idx_r == ISE_REG_OUT_B)
      |=> (o_exp0_port_b.flash_quad_lines_gate == $past(wr_data_r[5])
           && o_exp0_port_b.card_write_protect_gate == $past(wr_data_r[3])
           && o_exp0_port_b.coax_audio_gate == $past(wr_data_r[7])))
    else $error("card and flash gate lines do not follow write");

endmodule : i2c_switch_enable_expanders

// File: rtl/ise_expander_regs.sv
// Register bank of one expander: two direction and two output registers.
// Assumes write strobes and indices come from the bus target on the same clock.
`timescale 1ns/10ps
module ise_expander_regs
  import ise_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // Register access
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_reg_idx,
  input  wire logic [7:0] i_wr_data,
  output logic      [7:0] o_rd_data,
  // Port pins
  output logic      [7:0] o_port_a,
  output logic      [7:0] o_port_b,
  output logic      [7:0] o_drive_a,
  output logic      [7:0] o_drive_b
);

  logic [3:0] hit;
  logic [7:0] port_a_r;
  logic [7:0] port_b_r;
  logic [7:0] drive_a_r;
  logic [7:0] drive_b_r;

  assign hit = ise_reg_hit(i_reg_idx);

  // Drive enables are kept inverted so reset clears them and pins float
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      drive_a_r <= ISE_DRIVE_RST;
      drive_b_r <= ISE_DRIVE_RST;
    end else if (i_wr_en) begin
      if (hit[0]) drive_a_r <= ~i_wr_data;
      if (hit[1]) drive_b_r <= ~i_wr_data;
    end
  end

  // Output latches; a level only reaches the pin once its drive bit is set
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      port_a_r <= ISE_OUT_RST;
      port_b_r <= ISE_OUT_RST;
    end else if (i_wr_en) begin
      if (hit[2]) port_a_r <= i_wr_data;
      if (hit[3]) port_b_r <= i_wr_data;
    end
  end

  // Read back; direction reads as one for an input pin
  always_comb begin
    case (hit)
      4'h1:    o_rd_data = ~drive_a_r;
      4'h2:    o_rd_data = ~drive_b_r;
      4'h4:    o_rd_data = port_a_r;
      4'h8:    o_rd_data = port_b_r;
      default: o_rd_data = ISE_UNMAPPED;
    endcase
  end

  assign o_port_a  = port_a_r;
  assign o_port_b  = port_b_r;
  assign o_drive_a = drive_a_r;
  assign o_drive_b = drive_b_r;

  // Output latch write lands one cycle after the strobe
  out_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr_en && i_reg_idx == ISE_REG_OUT_B) |=> (port_b_r == $past(i_wr_data)))
    else $error("port B output latch missed a write");

  // Just out of reset nothing is driven
  reset_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!$past(i_nrst)) |-> (drive_a_r == 8'h00 && drive_b_r == 8'h00))
    else $error("pin driven right after reset");

  // A zero direction bit turns the pin into an output
  dir_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr_en && i_reg_idx == ISE_REG_DIR_A) ##1 (!i_wr_en)[*2]
      |-> (drive_a_r == ~$past(i_wr_data, 2)))
    else $error("direction A did not follow write");

endmodule : ise_expander_regs

// File: rtl/ise_pkg.sv
// Shared constants, types and decode for the switch-enable expander pair.
// Assumes a single system clock; the two-wire bus pins arrive asynchronously.
package ise_pkg;

  // Seven-bit target addresses of the two expanders
  localparam logic [6:0] ISE_EXP0_ADDR = 7'h21;
  localparam logic [6:0] ISE_EXP1_ADDR = 7'h22;

  // Register indices inside each expander
  localparam logic [7:0] ISE_REG_DIR_A = 8'h00;
  localparam logic [7:0] ISE_REG_DIR_B = 8'h01;
  localparam logic [7:0] ISE_REG_OUT_A = 8'h12;
  localparam logic [7:0] ISE_REG_OUT_B = 8'h13;

  // Values after reset: no pin driven, output latches cleared; unmapped indices read zero
  localparam logic [7:0] ISE_DRIVE_RST = 8'h00;
  localparam logic [7:0] ISE_OUT_RST   = 8'h00;
  localparam logic [7:0] ISE_UNMAPPED  = 8'h00;

  // Bits per byte on the bus
  localparam logic [3:0] ISE_BYTE_BITS = 4'h8;

  // Bus target sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_REG       = 9'h008,
    ST_REG_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } ise_state_t;

  // First expander, port A gate lines
  typedef struct packed {
    logic second_fieldbus_gate;
    logic first_fieldbus_gate;
    logic media_link_gate;
    logic spare4;
    logic spare3;
    logic serial_port_gate;
    logic serial_handshake_gate;
    logic eeprom_select_gate;
  } ise_exp0_pa_t;

  // First expander, port B gate lines
  typedef struct packed {
    logic coax_audio_gate;
    logic optical_audio_gate;
    logic flash_quad_lines_gate;
    logic flash_select_gate;
    logic card_write_protect_gate;
    logic jack_direction_select;
    logic audio_adc_gate;
    logic audio_dac_gate;
  } ise_exp0_pb_t;

  // One-hot register hit: {out_b, out_a, dir_b, dir_a}
  function automatic logic [3:0] ise_reg_hit(input logic [7:0] idx);
    ise_reg_hit = {idx == ISE_REG_OUT_B, idx == ISE_REG_OUT_A,
                   idx == ISE_REG_DIR_B, idx == ISE_REG_DIR_A};
  endfunction : ise_reg_hit

endpackage : ise_pkg

// File: verif/ise_twi_master.sv
// Behavioural two-wire bus master standing in for the processor controller.
// Assumes an external pull-up on SDA; SCL is driven push-pull and idles high.
`timescale 1ns/10ps
module ise_twi_master (
  // Clock and bus
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // Bus idle until the first frame
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // Wait a number of system clocks
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc

  // One bit; SDA moves only while SCL is low, two clocks after it falls, so data never mimics START or STOP
  task automatic bit_io(input logic b, output logic r);
    cyc(2);
    o_sda_oe <= ~b;
    cyc(6);
    o_scl <= 1'b1;
    cyc(4);
    r = i_sda; // Mid high phase, well clear of both edges
    cyc(4);
    o_scl <= 1'b0;
  endtask : bit_io

  // START, also used as repeated START from a low SCL
  task automatic start();
    cyc(2);
    o_sda_oe <= 1'b0;
    cyc(4);
    o_scl <= 1'b1;
    cyc(8);
    o_sda_oe <= 1'b1;
    cyc(8);
    o_scl <= 1'b0;
  endtask : start

  // STOP, leaving both lines released high
  task automatic stop();
    cyc(2);
    o_sda_oe <= 1'b1;
    cyc(6);
    o_scl <= 1'b1;
    cyc(8);
    o_sda_oe <= 1'b0;
    cyc(8);
  endtask : stop

  // Send a byte MSB first; nack is the sampled ninth bit
  task automatic tx(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, nack);
  endtask : tx

  // Receive a byte; last sends NACK to end the read
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rx
endmodule : ise_twi_master

// File: verif/tb.sv
// Testbench for the switch-enable expander pair, driven over the two-wire bus.
// Assumes the master model above; SDA is open drain with a pull-up modelled here.
`timescale 1ns/10ps
module tb;
  import ise_pkg::*;
  logic         i_clk_sys;
  logic         i_nrst;
  logic         scl;
  logic         m_oe;
  logic         sda;
  logic         o_sda_out;
  logic         o_sda_oe;
  ise_exp0_pa_t pa0;
  ise_exp0_pb_t pb0;
  logic [7:0]   lat_a[2];
  logic [7:0]   lat_b[2];
  logic [7:0]   oe_a[2];
  logic [7:0]   oe_b[2];
  logic [7:0]   d0;
  logic [7:0]   d1;
  logic [6:0]   adr;
  logic         n;
  int           miscompares;
  int           total_checks;

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

  // Clock and pulled-up open-drain data line
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  assign sda = ~(m_oe | (o_sda_oe & ~o_sda_out));
  assign lat_a[0] = pa0;
  assign lat_b[0] = pb0;

  ise_twi_master m (
    .i_clk_sys (i_clk_sys),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_oe  (m_oe)
  );

  i2c_switch_enable_expanders dut (
    .i_clk_sys        (i_clk_sys),
    .i_nrst           (i_nrst),
    .i_scl            (scl),
    .i_sda            (sda),
    .o_sda_out        (o_sda_out),
    .o_sda_oe         (o_sda_oe),
    .o_exp0_port_a    (pa0),
    .o_exp0_port_a_oe (oe_a[0]),
    .o_exp0_port_b    (pb0),
    .o_exp0_port_b_oe (oe_b[0]),
    .o_exp1_port_a    (lat_a[1]),
    .o_exp1_port_a_oe (oe_a[1]),
    .o_exp1_port_b    (lat_b[1]),
    .o_exp1_port_b_oe (oe_b[1])
  );

  // Write two bytes from index idx; every byte must be acknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, x, y);
    m.start();
    m.tx({a, 1'b0}, n);
    `CHK("addr ack", 1'b0, n)
    m.tx(idx, n);
    `CHK("index ack", 1'b0, n)
    m.tx(x, n);
    `CHK("data ack", 1'b0, n)
    m.tx(y, n);
    `CHK("data ack", 1'b0, n)
    m.stop();
  endtask : wr

  // Read two bytes from index idx through a repeated START
  task automatic rd(input logic [6:0] a, input logic [7:0] idx);
    m.start();
    m.tx({a, 1'b0}, n);
    m.tx(idx, n);
    m.start();
    m.tx({a, 1'b1}, n);
    `CHK("read addr ack", 1'b0, n)
    m.rx(1'b0, d0);
    m.rx(1'b1, d1);
    m.stop();
  endtask : rd

  // Print counts and verdict, then end the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog, far beyond the roughly 0.22 ms the tests need
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    i_nrst = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    for (int k = 0; k < 2; k++) begin
      `CHK("oe a", 8'h00, oe_a[k])
      `CHK("oe b", 8'h00, oe_b[k])
      adr = k ? ISE_EXP1_ADDR : ISE_EXP0_ADDR;
      rd(adr, ISE_REG_DIR_A);
      `CHK("dir a", 8'hFF, d0)
      `CHK("dir b", 8'hFF, d1)
      rd(adr, ISE_REG_OUT_A);
      `CHK("out a", 8'h00, d0)
      `CHK("out b", 8'h00, d1)
    end
    $display("test reset_state done");
    // Board defaults: levels first, then direction bits cleared
    for (int k = 0; k < 2; k++) begin
      adr = k ? ISE_EXP1_ADDR : ISE_EXP0_ADDR;
      d0 = k ? 8'hE0 : 8'h02;
      d1 = k ? 8'hFF : 8'hC4;
      wr(adr, ISE_REG_OUT_A, d0, d1);
      `CHK("latch a", d0, lat_a[k])
      `CHK("latch b", d1, lat_b[k])
      `CHK("oe a held", 8'h00, oe_a[k])
      `CHK("other latch", k ? 8'h02 : 8'h00, lat_a[1 - k])
      wr(adr, ISE_REG_DIR_A, 8'h00, 8'h00);
      `CHK("oe a", 8'hFF, oe_a[k])
      `CHK("oe b", 8'hFF, oe_b[k])
      rd(adr, ISE_REG_OUT_A);
      `CHK("read a", k ? 8'hE0 : 8'h02, d0)
      `CHK("read b", k ? 8'hFF : 8'hC4, d1)
    end
    // Gate lines of the first expander, singly or in pairs, against its defaults
    `CHK("eeprom gate", 1'b0, pa0.eeprom_select_gate)
    `CHK("handshake gate", 1'b1, pa0.serial_handshake_gate)
    `CHK("serial gate", 1'b0, pa0.serial_port_gate)
    `CHK("link gate", 1'b0, pa0.media_link_gate)
    `CHK("fieldbus gates", 2'b00, {pa0.second_fieldbus_gate, pa0.first_fieldbus_gate})
    `CHK("dac gate", 1'b0, pb0.audio_dac_gate)
    `CHK("adc gate", 1'b0, pb0.audio_adc_gate)
    `CHK("jack select", 1'b1, pb0.jack_direction_select)
    `CHK("card gate", 1'b0, pb0.card_write_protect_gate)
    `CHK("flash gates", 2'b00, {pb0.flash_select_gate, pb0.flash_quad_lines_gate})
    `CHK("digital audio gates", 2'b11, {pb0.optical_audio_gate, pb0.coax_audio_gate})
    $display("test board_defaults done");
    // Half the pins back to inputs; second byte lands on an unmapped index
    wr(ISE_EXP0_ADDR, ISE_REG_DIR_B, 8'h0F, 8'h5A);
    `CHK("oe b partial", 8'hF0, oe_b[0])
    `CHK("oe a kept", 8'hFF, oe_a[0])
    rd(ISE_EXP0_ADDR, ISE_REG_DIR_B);
    `CHK("dir b", 8'h0F, d0)
    `CHK("unmapped", 8'h00, d1)
    $display("test direction_bits done");
    // Neighbouring address must not be answered
    m.start();
    m.tx({7'h23, 1'b0}, n);
    m.stop();
    `CHK("foreign nack", 1'b1, n)
    `CHK("latch kept", 8'hC4, lat_b[0])
    $display("test foreign_address done");
    report_and_stop();
  end
endmodule : tb
